// file: design/slsl_top.v
// serializer sync pattern and deserializer lock tracking
`timescale 1ns/1ps
`include "slsl_defs.vh"
// Operation
// - request over six cycles sends 1026 patterns
// - pattern word is six ones, six zeros
// - serial output off until clock loop locks
// - clock loops initialized before any transfer
// - hunting starts only after input transitions
// - acquired indicator high until locked
// - locked outputs carry recovered words
// - lock achievable on data without repetitive multi-transition words
// - repetitive multi-transition data blocks lock
// - lock after four same-position boundaries
// - locked ignores repetitive data with boundary
// - four missing boundaries drop lock, rehunt
// - unlocked: indicator high, outputs released
// - word is ten data bits plus framing
// - start bit one, stop bit zero
module slsl_top #(
  parameter WORD_BITS   = `SLSL_WORD_BITS,
  parameter FIFO_DEPTH  = `SLSL_FIFO_DEPTH,
  parameter PAT_WORDS   = `SLSL_PAT_WORDS,
  parameter LOOP_CYCLES = `SLSL_CLK_LOOP_CYC
) (
  // clock and reset
  input  wire                 clk,
  input  wire                 sys_rst,
  // serializer side
  input  wire                 transmit_word_clock,
  input  wire                 pattern_request_a,
  input  wire                 pattern_request_b,
  input  wire [WORD_BITS-1:0] tx_word,
  input  wire                 tx_word_valid,
  output wire                 tx_word_ready,
  output reg                  ser_out,
  output reg                  ser_out_oe,
  output reg                  pattern_active,
  // deserializer side
  input  wire                 local_reference_clock,
  input  wire                 ser_in,
  output reg                  acquired_n,
  output reg  [WORD_BITS-1:0] parallel_word_out,
  output reg                  parallel_word_out_oe,
  output reg                  recovered_clk,
  output reg                  recovered_clk_oe,
  output reg                  false_lock_seen
);
  localparam FB = WORD_BITS + 2;

  // synchronisers for outside inputs
  reg [1:0] tck_s_q, rqa_s_q, rqb_s_q, ref_s_q, sin_s_q;
  reg       tck_d_q, ref_d_q;
  always @(posedge clk) begin
    if (sys_rst) begin
      tck_s_q <= 2'h0;
      rqa_s_q <= 2'h0;
      rqb_s_q <= 2'h0;
      ref_s_q <= 2'h0;
      sin_s_q <= 2'h0;
      tck_d_q <= 1'b0;
      ref_d_q <= 1'b0;
    end else begin
      tck_s_q <= {tck_s_q[0], transmit_word_clock};
      rqa_s_q <= {rqa_s_q[0], pattern_request_a};
      rqb_s_q <= {rqb_s_q[0], pattern_request_b};
      ref_s_q <= {ref_s_q[0], local_reference_clock};
      sin_s_q <= {sin_s_q[0], ser_in};
      tck_d_q <= tck_s_q[1];
      ref_d_q <= ref_s_q[1];
    end
  end
  wire tck_rise = tck_s_q[1] && !tck_d_q;
  wire ref_rise = ref_s_q[1] && !ref_d_q;
  wire req_any  = rqa_s_q[1] || rqb_s_q[1];

  // serializer: clock loop, request counter, framing shifter
  reg [7:0]  tloop_q;
  reg [2:0]  req_cnt_q;
  reg [10:0] pat_cnt_q;
  reg [FB-1:0] sh_q;
  reg [3:0]  bit_q;
  wire tlocked = (tloop_q == LOOP_CYCLES[7:0]);
  wire [WORD_BITS-1:0] f_data;
  wire       f_valid;
  wire       load = tck_rise && tlocked;
  wire       f_pop = load && !pattern_active && f_valid;

  slsl_fifo #(.WIDTH(WORD_BITS), .DEPTH(FIFO_DEPTH), .AW(3)) u_fifo (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .in_valid  (tx_word_valid),
    .in_ready  (tx_word_ready),
    .in_data   (tx_word),
    .out_valid (f_valid),
    .out_ready (f_pop),
    .out_data  (f_data)
  );

  always @(posedge clk) begin
    if (sys_rst) begin
      tloop_q        <= 8'h00;
      req_cnt_q      <= 3'h0;
      pat_cnt_q      <= 11'h000;
      pattern_active <= 1'b0;
      sh_q           <= {FB{1'b0}};
      bit_q          <= 4'h0;
      ser_out        <= 1'b0;
      ser_out_oe     <= 1'b0;
    end else begin
      if (tck_rise && !tlocked) begin
        tloop_q <= tloop_q + 8'h01;
      end
      ser_out_oe <= tlocked;
      if (tck_rise) begin
        if (!req_any) begin
          req_cnt_q <= 3'h0;
        end else if (req_cnt_q != 3'h7) begin
          req_cnt_q <= req_cnt_q + 3'h1;
        end
      end
      if (load) begin
        if (req_cnt_q > `SLSL_REQ_MIN && !pattern_active) begin
          pattern_active <= 1'b1;
          pat_cnt_q      <= PAT_WORDS[10:0] - 11'h001;
          sh_q           <= `SLSL_PAT_WORD;
        end else if (pattern_active) begin
          sh_q <= `SLSL_PAT_WORD;
          if (pat_cnt_q == 11'h000) begin
            pattern_active <= 1'b0;
            sh_q           <= {1'b1, f_data, 1'b0};
          end else begin
            pat_cnt_q <= pat_cnt_q - 11'h001;
          end
        end else begin
          sh_q <= {1'b1, (f_valid ? f_data : {WORD_BITS{1'b0}}), 1'b0};
        end
        bit_q <= 4'h0;
      end else if (bit_q != FB[3:0] - 4'h1) begin
        sh_q  <= {sh_q[FB-2:0], 1'b0};
        bit_q <= bit_q + 4'h1;
      end
      ser_out <= sh_q[FB-1];
    end
  end

  // deserializer: reference loop, bit window, boundary search
  reg [7:0]    rloop_q;
  reg          active_q;
  reg [FB-1:0] win_q;
  reg [3:0]    rpos_q, lpos_q;
  reg [2:0]    hit_q, miss_q, rmt_q;
  reg          bit_tick;
  wire rlocked = (rloop_q == LOOP_CYCLES[7:0]);
  wire sin_bit = sin_s_q[1];
  // stop bit then start bit at window edge; other window bits not checked
  wire         boundary = !win_q[FB-1] && win_q[FB-2];
  reg [3:0]    rises;
  integer      i;
  always @* begin
    rises = 4'h0;
    for (i = 0; i < FB - 1; i = i + 1) begin
      if (!win_q[i+1] && win_q[i]) begin
        rises = rises + 4'h1;
      end
    end
  end
  wire rmt_word = (rises > 4'h1);

  always @(posedge clk) begin
    if (sys_rst) begin
      rloop_q              <= 8'h00;
      active_q             <= 1'b0;
      win_q                <= {FB{1'b0}};
      rpos_q               <= 4'h0;
      lpos_q               <= 4'h0;
      hit_q                <= 3'h0;
      miss_q               <= 3'h0;
      rmt_q                <= 3'h0;
      bit_tick             <= 1'b0;
      acquired_n           <= 1'b1;
      parallel_word_out    <= {WORD_BITS{1'b0}};
      parallel_word_out_oe <= 1'b0;
      recovered_clk        <= 1'b0;
      recovered_clk_oe     <= 1'b0;
      false_lock_seen      <= 1'b0;
    end else begin
      if (ref_rise && !rlocked) begin
        rloop_q <= rloop_q + 8'h01;
      end
      bit_tick <= ref_rise;
      if (rlocked && sin_bit != win_q[0]) begin
        active_q <= 1'b1;
      end
      if (rlocked && bit_tick) begin
        win_q  <= {win_q[FB-2:0], sin_bit};
        rpos_q <= (rpos_q == FB[3:0] - 4'h1) ? 4'h0 : rpos_q + 4'h1;
        recovered_clk <= (rpos_q < FB[3:0] / 2) && !acquired_n;
        if (active_q && rpos_q == lpos_q) begin
          rmt_q <= rmt_word ? ((rmt_q == 3'h7) ? rmt_q : rmt_q + 3'h1) : 3'h0;
          false_lock_seen <= rmt_word && rmt_q >= `SLSL_RMT_WORDS - 1;
          if (acquired_n) begin
            if (boundary && !(rmt_word && rmt_q >= `SLSL_RMT_WORDS - 1)) begin
              hit_q <= hit_q + 3'h1;
              if (hit_q == `SLSL_LOCK_HITS - 1) begin
                acquired_n <= 1'b0;
                hit_q      <= 3'h0;
              end
            end else begin
              hit_q  <= 3'h0;
              lpos_q <= (lpos_q == FB[3:0] - 4'h1) ? 4'h0 : lpos_q + 4'h1;
            end
          end else begin
            if (boundary) begin
              miss_q            <= 3'h0;
              // start bit sits at window bit FB-2, so the data bits are below it
              parallel_word_out <= win_q[FB-3:0];
            end else begin
              miss_q <= miss_q + 3'h1;
              if (miss_q == `SLSL_LOSS_MISSES - 1) begin
                acquired_n <= 1'b1;
                miss_q     <= 3'h0;
              end
            end
          end
        end
      end
      parallel_word_out_oe <= !acquired_n;
      recovered_clk_oe     <= !acquired_n;
    end
  end
endmodule

// file: inc/slsl_defs.vh
// constants for the serdes link sync and lock block
`ifndef SLSL_DEFS_VH
`define SLSL_DEFS_VH
`define SLSL_WORD_BITS     10
`define SLSL_FRAME_BITS    12
`define SLSL_REQ_MIN       6
`define SLSL_PAT_WORDS     1026
`define SLSL_PAT_WORD      12'hFC0
`define SLSL_LOCK_HITS     4
`define SLSL_LOSS_MISSES   4
`define SLSL_RMT_WORDS     4
`define SLSL_CLK_LOOP_CYC  16
`define SLSL_FIFO_DEPTH    8
`endif

// file: design/slsl_fifo.v
// small synchronous fifo with valid and ready on both sides
`timescale 1ns/1ps
module slsl_fifo #(
  parameter WIDTH = 10,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  // clock and reset
  input  wire             clk,
  input  wire             sys_rst,
  // fill side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // drain side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_q;
  reg [AW-1:0]    rd_q;
  reg [AW:0]      cnt_q;
  wire            push;
  wire            pop;

  assign in_ready  = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data  = mem[rd_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always @(posedge clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
    if (sys_rst) begin
      wr_q  <= {AW{1'b0}};
      rd_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule

// file: verif/slsl_chk_assertions.sv
// checker on the link sync and lock ports
`timescale 1ns/1ps
module slsl_chk #(
  parameter PAT_WORDS   = 1026,
  parameter LOOP_CYCLES = 16,
  parameter WORD_CLKS   = 16
) (
  // clock and reset
  input wire clk,
  input wire sys_rst,
  // serializer side
  input wire transmit_word_clock,
  input wire pattern_request_a,
  input wire pattern_request_b,
  input wire ser_out_oe,
  input wire pattern_active,
  // deserializer side
  input wire acquired_n,
  input wire parallel_word_out_oe,
  input wire recovered_clk_oe,
  input wire false_lock_seen
);
  reg        twc_q;
  reg        lvl_q;
  reg [15:0] run_q;
  reg [15:0] pat_q;
  reg [15:0] rise_q;
  wire       req = pattern_request_a | pattern_request_b;
  // request run length, pattern length, word clock rises since reset
  always @(posedge clk) begin
    if (sys_rst) begin
      twc_q  <= 1'b0;
      lvl_q  <= 1'b0;
      run_q  <= 16'h0000;
      pat_q  <= 16'h0000;
      rise_q <= 16'h0000;
    end else begin
      twc_q  <= transmit_word_clock;
      lvl_q  <= req;
      if (req)
        run_q <= lvl_q ? run_q + 16'h0001 : 16'h0001;
      pat_q  <= pattern_active ? pat_q + 16'h0001 : 16'h0000;
      if (transmit_word_clock && !twc_q && rise_q != 16'hFFFF)
        rise_q <= rise_q + 16'h0001;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_pattern_start: assert property ($rose(pattern_active) |-> run_q >= 6 * WORD_CLKS - 6)
    else $error("pattern began on a short request");
  a_pattern_length: assert property ($fell(pattern_active) |->
    pat_q >= PAT_WORDS * WORD_CLKS - 16 && pat_q <= PAT_WORDS * WORD_CLKS + 16)
    else $error("pattern length off");
  a_oe_waits_loop: assert property ($rose(ser_out_oe) |-> rise_q >= LOOP_CYCLES)
    else $error("serial output enabled early");
  a_rmt_blocks: assert property (acquired_n && false_lock_seen |=> acquired_n)
    else $error("locked on repetitive data");
  a_lock_drives: assert property ($fell(acquired_n) |-> ##[0:1] parallel_word_out_oe)
    else $error("words not driven after lock");
  a_out_release: assert property ($rose(acquired_n) |=> !parallel_word_out_oe)
    else $error("words still driven after loss");
  a_clk_release: assert property (acquired_n && $past(acquired_n) |-> !recovered_clk_oe)
    else $error("word clock driven while unlocked");
  a_unlock_quiet: assert property (acquired_n && $past(acquired_n) |-> !parallel_word_out_oe)
    else $error("words driven while unlocked");
  c_pattern: cover property ($fell(pattern_active));
  c_lock: cover property ($fell(acquired_n));
  c_false: cover property ($rose(false_lock_seen));
endmodule

// file: verif/slsl_peer.sv
// companion serializer model driving the serial input
`timescale 1ns/1ps
module slsl_peer (
  // bench control
  input  wire       en,
  input  wire [9:0] word,
  // link
  output reg        ref_clk,
  output reg        ser_in
);
  wire [11:0] frame = {1'b1, word, 1'b0};
  integer     i;
  initial begin
    ref_clk = 1'b0;
    ser_in  = 1'b0;
    i       = 0;
    #20;
    // reference runs free; bit changes after its falling edge
    forever begin
      #40 ref_clk = 1'b1;
      #40 ref_clk = 1'b0;
      ser_in = en & frame[11 - i];
      i = (i == 11) ? 0 : i + 1;
    end
  end
endmodule

// file: verif/slsl_top_tb.sv
// bench for the link sync and lock block
`timescale 1ns/1ps
module slsl_top_tb;
  localparam PW = 8;
  localparam LC = 4;
  reg        clk = 1'b0;
  reg        sys_rst = 1'b1;
  reg        twc = 1'b0;
  reg        req_a = 1'b0;
  reg        req_b = 1'b0;
  reg        txv = 1'b0;
  reg        en = 1'b0;
  reg  [9:0] word = 10'h000;
  wire       ref_clk, ser_in, so, oe, pat, lk_n, p_oe, rclk, r_oe, fls, rdy;
  wire [9:0] pwo;
  integer    error_cnt = 0;
  integer    check_count = 0;
  integer    n;
  slsl_top #(.PAT_WORDS(PW), .LOOP_CYCLES(LC)) i_slsl_top (
    .clk(clk), .sys_rst(sys_rst), .transmit_word_clock(twc),
    .pattern_request_a(req_a), .pattern_request_b(req_b), .tx_word(10'h2AB),
    .tx_word_valid(txv), .tx_word_ready(rdy), .ser_out(so), .ser_out_oe(oe),
    .pattern_active(pat), .local_reference_clock(ref_clk), .ser_in(ser_in),
    .acquired_n(lk_n), .parallel_word_out(pwo), .parallel_word_out_oe(p_oe),
    .recovered_clk(rclk), .recovered_clk_oe(r_oe), .false_lock_seen(fls));
  slsl_peer i_slsl_peer (.en(en), .word(word), .ref_clk(ref_clk), .ser_in(ser_in));
  initial forever #2.5 clk = ~clk;
  initial forever #40 twc = ~twc;
  task chk(input [8*8:1] nm, input [15:0] e, input [15:0] g);
    begin
      check_count = check_count + 1;
      if (g !== e) begin
        error_cnt = error_cnt + 1;
        $display("ERROR %0s exp %0h got %0h", nm, e, g);
      end
    end
  endtask
  task t_loop;
    begin
      repeat (16) @(negedge clk);
      chk("ser_oe", 16'h0, oe);
      repeat (LC * 16 + 64) if (oe !== 1'b1) @(negedge clk);
      chk("ser_oe", 16'h1, oe);
    end
  endtask
  task t_pattern;
    begin
      req_a = 1'b1;
      repeat (80) @(negedge clk);
      req_a = 1'b0;
      repeat (64) @(negedge clk);
      chk("pat", 16'h0, pat);
      req_b = 1'b1;
      repeat (300) if (pat !== 1'b1) @(negedge clk);
      chk("pat", 16'h1, pat);
      req_b = 1'b0;
      repeat (40) if (so !== 1'b0) @(negedge clk);
      repeat (40) if (so !== 1'b1) @(negedge clk);
      n = 0;
      repeat (20) if (so === 1'b1) begin n = n + 1; @(negedge clk); end
      chk("ones", 16'h6, n[15:0]);
      txv = 1'b1;
      n = 0;
      repeat (12) begin if (rdy === 1'b1) n = n + 1; @(negedge clk); end
      txv = 1'b0;
      chk("fill", 16'h8, n[15:0]);
      repeat (PW * 16 + 64) if (pat !== 1'b0) @(negedge clk);
      chk("pat", 16'h0, pat);
      repeat (48) @(negedge clk);
      chk("drain", 16'h1, rdy);
    end
  endtask
  task t_rmt;
    begin
      word = 10'h155;
      en = 1'b1;
      n = 0;
      repeat (3000) begin @(negedge clk); if (lk_n !== 1'b1) n = n + 1; end
      chk("unlock", 16'h0, n[15:0]);
      chk("false", 16'h1, fls);
    end
  endtask
  task t_lock;
    begin
      word = 10'h3E0;
      repeat (384) @(negedge clk);
      chk("lock_n", 16'h1, lk_n);
      repeat (6000) if (lk_n !== 1'b0) @(negedge clk);
      chk("lock_n", 16'h0, lk_n);
      repeat (2) @(negedge clk);
      chk("out_oe", 16'h1, p_oe);
      chk("clk_oe", 16'h1, r_oe);
      repeat (200) @(negedge clk);
      chk("data", 16'h3E0, pwo);
    end
  endtask
  task t_loss;
    begin
      word = 10'h155;
      n = 0;
      repeat (1000) begin @(negedge clk); if (lk_n !== 1'b0) n = n + 1; end
      chk("held", 16'h0, n[15:0]);
      en = 1'b0;
      repeat (3000) if (lk_n !== 1'b1) @(negedge clk);
      chk("lock_n", 16'h1, lk_n);
      repeat (2) @(negedge clk);
      chk("out_oe", 16'h0, p_oe);
      chk("clk_oe", 16'h0, r_oe);
    end
  endtask
  task t_relock;
    begin
      req_a = lk_n;
      repeat (300) if (pat !== 1'b1) @(negedge clk);
      chk("pat", 16'h1, pat);
      word = 10'h3E0;
      en = 1'b1;
      repeat (6000) begin @(negedge clk); req_a = lk_n; end
      chk("lock_n", 16'h0, lk_n);
      repeat (PW * 16 + 64) @(negedge clk);
      chk("pat", 16'h0, pat);
    end
  endtask
  task summarize;
    begin
      if (error_cnt == 0 && check_count > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  initial begin
    repeat (8) @(negedge clk);
    chk("lock_n", 16'h1, lk_n);
    sys_rst = 1'b0;
    t_loop;
    t_pattern;
    t_rmt;
    t_lock;
    t_loss;
    t_relock;
    summarize;
  end
  initial begin
    #200000;
    error_cnt = error_cnt + 1;
    summarize;
  end
endmodule
bind slsl_top slsl_chk #(.PAT_WORDS(PAT_WORDS), .LOOP_CYCLES(LOOP_CYCLES)) i_slsl_chk (
  .clk(clk), .sys_rst(sys_rst), .transmit_word_clock(transmit_word_clock),
  .pattern_request_a(pattern_request_a), .pattern_request_b(pattern_request_b),
  .ser_out_oe(ser_out_oe), .pattern_active(pattern_active), .acquired_n(acquired_n),
  .parallel_word_out_oe(parallel_word_out_oe), .recovered_clk_oe(recovered_clk_oe),
  .false_lock_seen(false_lock_seen));
